// >>> timer_regs.vh
// Register map, field positions and reset values of the 16-bit timer block
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH
`define OFS_CONTROL_ONE   8'h00
`define OFS_CONTROL_TWO   8'h04
`define OFS_STATUS        8'h08
`define OFS_CAPTURE_ONE   8'h0c
`define OFS_COMPARE_ONE   8'h10
`define OFS_COUNTER       8'h14
`define OFS_ALT_COUNTER   8'h18
`define OFS_CAPTURE_TWO   8'h1c
`define OFS_COMPARE_TWO   8'h20
// Control one fields
`define C1_CAPTURE_IRQ_EN 7
`define C1_COMPARE_IRQ_EN 6
`define C1_OVERFLOW_IRQ_EN 5
`define C1_FORCE_TWO      4
`define C1_FORCE_ONE      3
`define C1_LEVEL_TWO      2
`define C1_CAPTURE_EDGE_ONE 1
`define C1_LEVEL_ONE      0
// Control two fields
`define C2_PIN_ONE_EN     7
`define C2_PIN_TWO_EN     6
`define C2_SINGLE_PULSE   5
`define C2_PWM            4
`define C2_CLOCK_SEL_HI   3
`define C2_CLOCK_SEL_LO   2
`define C2_CAPTURE_EDGE_TWO 1
`define C2_EXT_EDGE       0
// Status fields
`define ST_CAPTURE_ONE    7
`define ST_COMPARE_ONE    6
`define ST_OVERFLOW       5
`define ST_CAPTURE_TWO    4
`define ST_COMPARE_TWO    3
`define ST_TIMER_OFF      2
// Clock select codes
`define CLK_DIV4          2'h0
`define CLK_DIV2          2'h1
`define CLK_DIV8          2'h2
`define CLK_EXT           2'h3
// Reset and reload values
`define RST_CONTROL       8'h00
`define RST_COMPARE       16'h8000
`define COUNTER_RELOAD    16'hfffc
`define PULSE_CAPTURE     16'hfffd
`define COUNTER_TOP       16'hffff
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

// >>> timer_control.v
// 16-bit capture/compare timer with AXI4-Lite register access
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "timer_regs.vh"

// What this block does
// - All five timer events share one interrupt, gated by enables and cpu mask.
// - Capture one flag sets on capture one or pwm period reset; raises interrupt and wake alike.
// - Pulse-width mode raises no compare one or compare two events.
// - Control one bit 7 enables interrupt from either capture flag.
// - Control one bit 6 enables interrupt from either compare flag.
// - Control one bit 5 enables interrupt from the overflow flag.
// - Control one bit 4 forces level two onto enabled pin two.
// - Control one bit 3 forces level one onto enabled pin one.
// - Compare two match drives level two onto pin two, onto pin one in pwm mode, no pin in single pulse.
// - Control one bit 0 is pin one level on compare one match.
// - Control one bit 1 picks capture one edge: 0 falling, 1 rising.
// - Control two bit 7 only connects pin one; compare one keeps running.
// - Control two bit 6 only connects pin two; compare two keeps running.
// - Control two bit 5: capture one edge starts one pulse, length from compare one.
// - Control two bit 4: repeating waveform, compare one length, compare two period.
// - Clock select 00 div4, 01 div2, 10 div8, 11 external clock.
// - External clock selected without external pin stops the counter.
// - Control two bit 1 picks capture two edge: 0 falling, 1 rising.
// - Control two bit 0 picks external clock edge: 0 falling, 1 rising.
// - Three control/status registers and six 16-bit data registers.
// - Both pulse mode bits set means pulse-width mode only.
// - Flag clears after status read then access to its data register.
// - Overflow flag sets when counter rolls from ffff to 0000.
// - Pulse-width compare two match reloads counter with fffc.
module timer_control #(
  parameter HAS_EXT_CLOCK = 1
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  input  wire        cpu_irq_mask,
  input  wire        halt_mode,
  input  wire        capture_input_one,
  input  wire        capture_input_two,
  input  wire        ext_clock_pin,
  output reg         compare_pin_one,
  output reg         compare_pin_one_oe,
  output reg         compare_pin_two,
  output reg         compare_pin_two_oe,
  output reg         timer_irq,
  output reg         wait_wakeup
);

  reg  [7:0]  timer_control_one;
  reg  [7:0]  timer_control_two;
  reg         timer_off;
  reg  [4:0]  flags;
  reg  [4:0]  armed;
  reg  [15:0] capture_one;
  reg  [15:0] capture_two;
  reg  [15:0] compare_value_one;
  reg  [15:0] compare_value_two;
  reg  [15:0] counter;
  reg  [2:0]  prescale;
  reg  [2:0]  cap1_sync;
  reg  [2:0]  cap2_sync;
  reg  [2:0]  ext_sync;
  reg         aw_hold;
  reg         w_hold;
  reg  [7:0]  waddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;

  // Flag vector order: capture one, compare one, overflow, capture two, compare two
  wire        capture_irq_enable  = timer_control_one[`C1_CAPTURE_IRQ_EN];
  wire        compare_irq_enable  = timer_control_one[`C1_COMPARE_IRQ_EN];
  wire        overflow_irq_enable = timer_control_one[`C1_OVERFLOW_IRQ_EN];
  wire        force_level_two     = timer_control_one[`C1_FORCE_TWO];
  wire        force_level_one     = timer_control_one[`C1_FORCE_ONE];
  wire        output_level_two    = timer_control_one[`C1_LEVEL_TWO];
  wire        capture_edge_one    = timer_control_one[`C1_CAPTURE_EDGE_ONE];
  wire        output_level_one    = timer_control_one[`C1_LEVEL_ONE];
  wire        pin_one_enable      = timer_control_two[`C2_PIN_ONE_EN];
  wire        pin_two_enable      = timer_control_two[`C2_PIN_TWO_EN];
  wire        pwm_mode            = timer_control_two[`C2_PWM];
  // Pulse-width mode overrides single pulse mode
  wire        single_pulse_mode   = timer_control_two[`C2_SINGLE_PULSE] & ~pwm_mode;
  wire [1:0]  clock_select        = timer_control_two[`C2_CLOCK_SEL_HI:`C2_CLOCK_SEL_LO];
  wire        capture_edge_two    = timer_control_two[`C2_CAPTURE_EDGE_TWO];
  wire        ext_clock_edge      = timer_control_two[`C2_EXT_EDGE];

  function edge_seen;
    input [1:0] hist;
    input       rising;
    begin
      edge_seen = rising ? (hist == 2'b01) : (hist == 2'b10);
    end
  endfunction

  function is_data_reg;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      is_data_reg = (addr == ofs);
    end
  endfunction

  // Stage 0 feeds only stage 1; edges are taken between stages 1 and 2
  wire cap1_edge = edge_seen(cap1_sync[2:1], capture_edge_one);
  wire cap2_edge = edge_seen(cap2_sync[2:1], capture_edge_two);
  wire ext_edge  = edge_seen(ext_sync[2:1], ext_clock_edge);

  // Pin edges reach the counter three cycles after the pin moves;
  // an external clock faster than half of aclk loses edges
  reg tick;
  always @* begin
    case (clock_select)
      `CLK_DIV4: tick = (prescale[1:0] == 2'h3);
      `CLK_DIV2: tick = prescale[0];
      `CLK_DIV8: tick = (prescale == 3'h7);
      `CLK_EXT:  tick = (HAS_EXT_CLOCK != 0) && ext_edge;
      default:   tick = 1'b0;
    endcase
  end

  wire run       = tick & ~timer_off;
  wire match_one = run && (counter == compare_value_one);
  wire match_two = run && (counter == compare_value_two);
  wire pulse_go  = single_pulse_mode & cap1_edge & ~timer_off;

  // Register bus decode
  wire        wr_fire = aw_hold & w_hold & ~bvalid;
  wire        rd_fire = arvalid & arready;
  wire [7:0]  rd_addr = araddr;

  function mapped;
    input [7:0] addr;
    begin
      case (addr)
        `OFS_CONTROL_ONE, `OFS_CONTROL_TWO, `OFS_STATUS,
        `OFS_CAPTURE_ONE, `OFS_COMPARE_ONE, `OFS_COUNTER,
        `OFS_ALT_COUNTER, `OFS_CAPTURE_TWO, `OFS_COMPARE_TWO: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  // Alternate counter shows the same count; only its clear effect differs
  reg [31:0] read_value;
  always @* begin
    case (rd_addr)
      `OFS_CONTROL_ONE: read_value = {24'h0, timer_control_one};
      `OFS_CONTROL_TWO: read_value = {24'h0, timer_control_two};
      `OFS_STATUS:      read_value = {24'h0, flags, timer_off, 2'h0};
      `OFS_CAPTURE_ONE: read_value = {16'h0, capture_one};
      `OFS_COMPARE_ONE: read_value = {16'h0, compare_value_one};
      `OFS_COUNTER:     read_value = {16'h0, counter};
      `OFS_ALT_COUNTER: read_value = {16'h0, counter};
      `OFS_CAPTURE_TWO: read_value = {16'h0, capture_two};
      `OFS_COMPARE_TWO: read_value = {16'h0, compare_value_two};
      default:          read_value = 32'h0;
    endcase
  end

  // Accesses that complete the two-step flag clear; alternate counter excluded
  wire [7:0] wa = waddr_q;
  wire [4:0] rd_touch = rd_fire ? {is_data_reg(rd_addr, `OFS_CAPTURE_ONE),
                                   is_data_reg(rd_addr, `OFS_COMPARE_ONE),
                                   is_data_reg(rd_addr, `OFS_COUNTER),
                                   is_data_reg(rd_addr, `OFS_CAPTURE_TWO),
                                   is_data_reg(rd_addr, `OFS_COMPARE_TWO)} : 5'h0;
  wire [4:0] wr_touch = wr_fire ? {is_data_reg(wa, `OFS_CAPTURE_ONE),
                                   is_data_reg(wa, `OFS_COMPARE_ONE),
                                   is_data_reg(wa, `OFS_COUNTER),
                                   is_data_reg(wa, `OFS_CAPTURE_TWO),
                                   is_data_reg(wa, `OFS_COMPARE_TWO)} : 5'h0;
  wire [4:0] clear_now = armed & (rd_touch | wr_touch);
  wire       status_rd = rd_fire && (rd_addr == `OFS_STATUS);

  // New events this cycle; compare flags are silent in pulse-width mode
  // Capture one pin is cut off from the timer in pulse-width mode
  wire cap1_event = (cap1_edge & ~pwm_mode & ~timer_off) | pulse_go
                    | (pwm_mode & match_two);
  wire cmp1_event = match_one & ~pwm_mode & ~single_pulse_mode;
  wire cmp2_event = match_two & ~pwm_mode;
  wire ovf_event  = run && (counter == `COUNTER_TOP) && !(pwm_mode && match_two);
  wire cap2_event = cap2_edge & ~timer_off;
  wire [4:0] set_now = {cap1_event, cmp1_event, ovf_event, cap2_event, cmp2_event};

  wire counter_write = wr_fire && (wa == `OFS_COUNTER || wa == `OFS_ALT_COUNTER);

  // Interrupt and wake conditions
  wire [4:0] next_flags = (flags & ~clear_now) | set_now;
  wire       any_enabled = (capture_irq_enable & (next_flags[4] | next_flags[1]))
                         | (compare_irq_enable & (next_flags[3] | next_flags[0]))
                         | (overflow_irq_enable & next_flags[2]);

  // Two synchroniser stages per pin, a third stage holds edge history
  always @(posedge aclk) begin
    if (!aresetn) begin
      cap1_sync <= 3'h0;
      cap2_sync <= 3'h0;
      ext_sync  <= 3'h0;
    end else begin
      cap1_sync <= {cap1_sync[1:0], capture_input_one};
      cap2_sync <= {cap2_sync[1:0], capture_input_two};
      ext_sync  <= {ext_sync[1:0], ext_clock_pin};
    end
  end

  // AXI4-Lite handshakes
  // Readies drop at each hand-off and return once the response is accepted,
  // so at most one write and one read are under way
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      waddr_q <= 8'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_hold <= 1'b1;
        awready <= 1'b0;
        waddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold  <= 1'b1;
        wready  <= 1'b0;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= mapped(wa) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
      if (rd_fire) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= read_value;
        rresp   <= mapped(rd_addr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // Registers, counter, flags and pins
  always @(posedge aclk) begin
    if (!aresetn) begin
      timer_control_one  <= `RST_CONTROL;
      timer_control_two  <= `RST_CONTROL;
      timer_off          <= 1'b0;
      flags              <= 5'h0;
      armed              <= 5'h0;
      capture_one        <= 16'h0;
      capture_two        <= 16'h0;
      compare_value_one  <= `RST_COMPARE;
      compare_value_two  <= `RST_COMPARE;
      counter            <= `COUNTER_RELOAD;
      prescale           <= 3'h0;
      compare_pin_one    <= 1'b0;
      compare_pin_two    <= 1'b0;
      compare_pin_one_oe <= 1'b0;
      compare_pin_two_oe <= 1'b0;
      timer_irq          <= 1'b0;
      wait_wakeup        <= 1'b0;
    end else begin
      // Lane zero carries the 8-bit registers and the low bytes
      if (wr_fire && wstrb_q[0]) begin
        case (wa)
          `OFS_CONTROL_ONE: timer_control_one <= wdata_q[7:0];
          `OFS_CONTROL_TWO: timer_control_two <= wdata_q[7:0];
          `OFS_STATUS:      timer_off <= wdata_q[`ST_TIMER_OFF];
          `OFS_COMPARE_ONE: compare_value_one[7:0] <= wdata_q[7:0];
          `OFS_COMPARE_TWO: compare_value_two[7:0] <= wdata_q[7:0];
          default: ;
        endcase
      end
      // High byte of a compare value needs lane one
      if (wr_fire && wstrb_q[1]) begin
        if (wa == `OFS_COMPARE_ONE)
          compare_value_one[15:8] <= wdata_q[15:8];
        if (wa == `OFS_COMPARE_TWO)
          compare_value_two[15:8] <= wdata_q[15:8];
      end

      // Set wins over clear in the same cycle
      flags <= next_flags;
      // Arm only flags set now; later flags need a fresh status read
      if (status_rd)
        armed <= flags;
      else
        armed <= armed & ~clear_now;

      // Frozen prescaler while the timer is switched off
      if (!timer_off)
        prescale <= prescale + 3'h1;

      // Software reload and pulse start outrank the period reload
      if (counter_write || pulse_go)
        counter <= `COUNTER_RELOAD;
      else if (pwm_mode && match_two)
        counter <= `COUNTER_RELOAD;
      else if (run)
        counter <= counter + 16'h1;

      // Single pulse start stores a fixed value, not the count
      if (pulse_go)
        capture_one <= `PULSE_CAPTURE;
      else if (cap1_edge && !pwm_mode && !timer_off)
        capture_one <= counter;
      if (cap2_event)
        capture_two <= counter;

      // Pin one level; compare logic runs whatever the pin enable says
      if (force_level_one && pin_one_enable)
        compare_pin_one <= output_level_one;
      else if (pwm_mode || single_pulse_mode) begin
        if (pulse_go || (pwm_mode && match_two))
          compare_pin_one <= output_level_two;
        else if (match_one)
          compare_pin_one <= output_level_one;
      end else if (match_one)
        compare_pin_one <= output_level_one;

      // Level two belongs to pin one in the pulse modes
      if (force_level_two && pin_two_enable)
        compare_pin_two <= output_level_two;
      else if (match_two && !pwm_mode && !single_pulse_mode)
        compare_pin_two <= output_level_two;

      // Timer off releases both pins; pin levels are kept
      compare_pin_one_oe <= pin_one_enable & ~timer_off;
      compare_pin_two_oe <= pin_two_enable & ~timer_off;

      // Interrupt holds while any enabled flag is still set
      // Halt blocks only the wake request; the interrupt still stands
      timer_irq   <= any_enabled & ~cpu_irq_mask;
      wait_wakeup <= any_enabled & ~cpu_irq_mask & ~halt_mode;
    end
  end

endmodule // timer_control

// >>> timer_control_sva.sv
// Port assertions for the timer control block
`timescale 1ns/10ps
module timer_control_sva (
  input wire        aclk,
  input wire        aresetn,
  input wire [7:0]  awaddr,
  input wire        awvalid,
  input wire        awready,
  input wire [31:0] wdata,
  input wire [3:0]  wstrb,
  input wire        wvalid,
  input wire        wready,
  input wire        bvalid,
  input wire [7:0]  araddr,
  input wire        arvalid,
  input wire        arready,
  input wire [31:0] rdata,
  input wire [1:0]  rresp,
  input wire        rvalid,
  input wire        rready,
  input wire        cpu_irq_mask,
  input wire        halt_mode,
  input wire        compare_pin_one,
  input wire        compare_pin_one_oe,
  input wire        compare_pin_two_oe,
  input wire        timer_irq,
  input wire        wait_wakeup
);
  default clocking dcb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire wr_take = awvalid && awready && wvalid && wready;
  wire wr_two  = wr_take && awaddr == 8'h04 && wstrb[0];
  property p_mask; cpu_irq_mask |=> !timer_irq; endproperty
  property p_halt; halt_mode |=> !wait_wakeup; endproperty
  property p_wr_ans; wr_take |=> !awready && !wready ##1 bvalid; endproperty
  property p_rd_ans; arvalid && arready |=> rvalid && !arready; endproperty
  property p_rd_done; rvalid && rready |=> !rvalid; endproperty
  property p_unmap; arvalid && arready && araddr == 8'h24 |=> rresp == 2'h2 && rdata == 32'h0; endproperty
  // Pin release must follow the write, not wait for a match
  property p_oe_one; wr_two && !wdata[7] |-> ##[1:3] !compare_pin_one_oe; endproperty
  property p_oe_two; wr_two && !wdata[6] |-> ##[1:3] !compare_pin_two_oe; endproperty
  a_mask: assert property (p_mask) else $error("irq while masked");
  a_halt: assert property (p_halt) else $error("wakeup in halt");
  a_wr_ans: assert property (p_wr_ans) else $error("no write answer");
  a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
  a_rd_done: assert property (p_rd_done) else $error("rvalid stuck");
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  a_oe_one: assert property (p_oe_one) else $error("pin one still driven");
  a_oe_two: assert property (p_oe_two) else $error("pin two still driven");
  c_irq: cover property ($rose(timer_irq));
  c_pin: cover property ($rose(compare_pin_one));
  c_err: cover property (rvalid && rresp == 2'h2);
endmodule // timer_control_sva
bind timer_control timer_control_sva i_timer_control_sva (.*);

// >>> timer_pins_model.sv
// Far-side model: external clock source for the timer
`timescale 1ns/10ps
module timer_pins_model (
  input  wire       aclk,
  input  wire       go,
  input  wire [3:0] pulses,
  output reg        ext_clock_pin
);
  reg [3:0] left = 4'h0;
  reg [2:0] phase = 3'h0;
  initial ext_clock_pin = 1'b0;
  // Eight-cycle period stays well below the synchroniser limit; rests low between bursts
  always @(posedge aclk) begin
    if (go) begin
      left <= pulses;
      phase <= 3'h0;
    end else if (left != 4'h0) begin
      phase <= phase + 3'h1;
      if (phase == 3'h7)
        left <= left - 4'h1;
    end
    ext_clock_pin <= (left != 4'h0) && !phase[2];
  end
endmodule // timer_pins_model

// >>> timer_control_tb_top.sv
// Self-checking bench for the timer control block
`timescale 1ns/10ps
module timer_control_tb_top;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] s;} row_t;
  reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  reg  [7:0]  awaddr, araddr;
  reg  [31:0] wdata;
  reg  [3:0]  wstrb, ext_n;
  reg         cpu_irq_mask, halt_mode, capture_input_one, capture_input_two, ext_go;
  wire        awready, wready, bvalid, arready, rvalid, timer_irq, wait_wakeup, ext_clock_pin;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire        compare_pin_one, compare_pin_one_oe, compare_pin_two, compare_pin_two_oe;
  int         failures, cmp_count, hi, lo;
  logic [31:0] d;
  logic [1:0]  s;
  logic [7:0]  data_ofs [5] = '{8'h0c, 8'h10, 8'h14, 8'h1c, 8'h20};
  logic [31:0] modes [2] = '{32'h94, 32'hb4};
  row_t rows [5] = '{'{8'h00, 32'hffffff4a, 32'h4a, 2'h0}, '{8'h04, 32'h12, 32'h12, 2'h0},
    '{8'h10, 32'h00011234, 32'h1234, 2'h0}, '{8'h20, 32'h5678, 32'h5678, 2'h0}, '{8'h24, 32'h1, 32'h0, 2'h2}};
  timer_control i_timer_control (.*);
  timer_pins_model i_timer_pins_model (.aclk, .go(ext_go), .pulses(ext_n), .ext_clock_pin);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    s = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    s = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Status read arms every set flag, the data accesses then clear them
  task automatic clear_flags;
    rd(8'h08);
    foreach (data_ofs[i]) rd(data_ofs[i]);
  endtask
  task finish_test;
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    finish_test;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, ext_n} = '0;
    {cpu_irq_mask, halt_mode, capture_input_one, capture_input_two, ext_go} = '0;
    wstrb = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      check("wr resp", s, rows[i].s);
      rd(rows[i].a);
      check("readback", d, rows[i].q);
      check("rd resp", s, rows[i].s);
    end
    // Mid-run reset must restore the reset values: zero controls, 8000 compares
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i]) begin
      rd(rows[i].a);
      check("reset value", d, rows[i].a == 8'h00 || rows[i].a == 8'h04 || rows[i].a == 8'h24 ? 0 : 32'h8000);
    end
    // Short compare values so a period fits in a few dozen cycles; capture one left alone
    wr(8'h10, 32'h4);
    wr(8'h20, 32'h8);
    wr(8'h00, 32'h04);
    foreach (modes[m]) begin
      wr(8'h04, modes[m]);
      clear_flags;
      hi = 0;
      lo = 0;
      repeat (80) begin
        @(posedge aclk);
        if (compare_pin_one === 1'b1) hi++;
        if (compare_pin_one === 1'b0) lo++;
      end
      check("pwm levels", {hi > 0, lo > 0, compare_pin_one_oe}, 3'b111);
      rd(8'h08);
      check("pwm flags", d & 32'hc8, 32'h80);
    end
    wr(8'h04, 32'hc0);
    for (int l = 1; l >= 0; l--) begin
      wr(8'h00, l ? 32'h1d : 32'h18);
      repeat (3) @(posedge aclk);
      check("forced pins", {compare_pin_one, compare_pin_two, compare_pin_one_oe, compare_pin_two_oe}, {l[0], l[0], 2'b11});
    end
    wr(8'h04, 32'h0);
    repeat (3) @(posedge aclk);
    check("pins released", {compare_pin_one_oe, compare_pin_two_oe}, 2'b00);
    wr(8'h04, 32'hc4);
    wr(8'h00, 32'h25);
    clear_flags;
    wr(8'h14, 32'h0);
    repeat (30) @(posedge aclk);
    check("ovf irq", timer_irq, 1'b1);
    check("match pins", {compare_pin_one, compare_pin_two}, 2'b11);
    rd(8'h08);
    check("ovf flag", d & 32'h20, 32'h20);
    check("match flags", d & 32'h48, 32'h48);
    cpu_irq_mask <= 1'b1;
    repeat (3) @(posedge aclk);
    check("masked irq", timer_irq, 1'b0);
    cpu_irq_mask <= 1'b0;
    halt_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    check("halt wakeup", {timer_irq, wait_wakeup}, 2'b10);
    halt_mode <= 1'b0;
    repeat (3) @(posedge aclk);
    check("wait wakeup", wait_wakeup, 1'b1);
    wr(8'h00, 32'h0);
    check("ovf irq off", timer_irq, 1'b0);
    wr(8'h00, 32'h20);
    rd(8'h08);
    rd(8'h18);
    check("alt keeps flag", timer_irq, 1'b1);
    rd(8'h14);
    repeat (2) @(posedge aclk);
    check("flag cleared", timer_irq, 1'b0);
    for (int c = 0; c < 2; c++)
      for (int e = 0; e < 2; e++) begin
        wr(8'h00, c ? 32'h80 : 32'h80 | (e << 1));
        wr(8'h04, c ? e << 1 : 0);
        clear_flags;
        for (int k = 0; k < 2; k++) begin
          if (c) capture_input_two <= !capture_input_two;
          else capture_input_one <= !capture_input_one;
          repeat (8) @(posedge aclk);
          check("capture irq", timer_irq, (k == 0) == (e == 1));
          rd(8'h08);
          check("capture flag", d[c ? 4 : 7], (k == 0) == (e == 1));
          rd(c ? 8'h1c : 8'h0c);
        end
      end
    // Single pulse on a capture one edge at the slowest prescale
    wr(8'h04, 32'ha8);
    wr(8'h00, 32'h08);
    wr(8'h00, 32'h06);
    capture_input_one <= 1'b1;
    repeat (8) @(posedge aclk);
    check("pulse start", {compare_pin_one, compare_pin_one_oe}, 2'b11);
    rd(8'h0c);
    check("pulse capture", d, 32'hfffd);
    repeat (80) @(posedge aclk);
    check("pulse end", compare_pin_one, 1'b0);
    wr(8'h08, 32'h4);
    rd(8'h14);
    lo = d;
    repeat (20) @(posedge aclk);
    rd(8'h14);
    check("timer off", {d == lo, compare_pin_one_oe}, 2'b10);
    wr(8'h08, 32'h0);
    for (int e = 0; e < 2; e++) begin
      wr(8'h04, 32'h0c | e);
      wr(8'h14, 32'h0);
      ext_n <= 4'h3;
      ext_go <= 1'b1;
      @(posedge aclk);
      ext_go <= 1'b0;
      repeat (40) @(posedge aclk);
      rd(8'h14);
      check("ext count", d, 32'hffff);
    end
    finish_test;
  end
endmodule // timer_control_tb_top
